// file: spdp_pkg.sv
package spdp_pkg;
    // command port widths
    localparam int CMD_W = 16;
    localparam int DATA_W = 32;
    // field widths of the parameter registers
    localparam int SCALE_W = 11;
    localparam int IDENT_W = 16;
    localparam int RDP_W = 24;
    localparam int CURVE_W = 16;
    localparam int CORR_W = 17;
    localparam int SPEED_W = 17;
    localparam int PULSE_W = 28;
    // field positions inside the scale register word
    localparam int SCALE_LSB = 0;
    localparam int IDENT_LSB = 16;
    // identification monitor command
    localparam logic [15:0] CMD_IDENT_MON = 16'h0003;
    // speed scale commands
    localparam logic [15:0] CMD_WR_SCALE_PRE = 16'h00b5;
    localparam logic [15:0] CMD_RD_SCALE_PRE = 16'h00c5;
    localparam logic [15:0] CMD_WR_SCALE = 16'h0095;
    localparam logic [15:0] CMD_RD_SCALE = 16'h00d5;
    // ramp-down point commands
    localparam logic [15:0] CMD_WR_RDP_PRE = 16'h00b6;
    localparam logic [15:0] CMD_RD_RDP_PRE = 16'h00c6;
    localparam logic [15:0] CMD_WR_RDP = 16'h0096;
    localparam logic [15:0] CMD_RD_RDP = 16'h00d6;
    // acceleration s-curve commands
    localparam logic [15:0] CMD_WR_ACC_PRE = 16'h00b9;
    localparam logic [15:0] CMD_RD_ACC_PRE = 16'h00c9;
    localparam logic [15:0] CMD_WR_ACC = 16'h0099;
    localparam logic [15:0] CMD_RD_ACC = 16'h00d9;
    // deceleration s-curve commands
    localparam logic [15:0] CMD_WR_DEC_PRE = 16'h00ba;
    localparam logic [15:0] CMD_RD_DEC_PRE = 16'h00ca;
    localparam logic [15:0] CMD_WR_DEC = 16'h009a;
    localparam logic [15:0] CMD_RD_DEC = 16'h00da;
    // correction speed commands (no pre-register)
    localparam logic [15:0] CMD_WR_CORR = 16'h009b;
    localparam logic [15:0] CMD_RD_CORR = 16'h00db;
    // clamp limits
    localparam logic [15:0] CURVE_MAX = 16'hc350;
    localparam logic [16:0] CORR_MAX = 17'h186a0;
    // reset values
    localparam logic [10:0] SCALE_RST = 11'h002;
    localparam logic [23:0] RDP_RST = 24'h000000;
    localparam logic [15:0] CURVE_RST = 16'h0000;
    localparam logic [16:0] CORR_RST = 17'h00000;
    // identification code; value is arbitrary
    localparam logic [15:0] IDENT_CODE = 16'h5a01;
    // latency of the scaling multipliers in clocks
    localparam int SCALE_LAT = 1;
endpackage

// file: spdp_scale.sv
`timescale 1ns/1ns
// registered product of the speed scale and a base value
module spdp_scale #(
    parameter int AW = 11,
    parameter int BW = 17
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // operands
    input wire logic [AW-1:0] scale,
    input wire logic [BW-1:0] base,
    // result
    output logic [AW+BW-1:0] product
);
    ////////////////////////////////////////////////////////////////////////
    // one register stage keeps the multiplier off the output timing path
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            product <= '0;
        end else begin
            product <= scale * base;
        end
    end
endmodule

// file: spdp_regs.sv
`timescale 1ns/1ns
// Behaviour
// - 11-bit scale field, bits 15..11 read zero
// - pulse rate equals scale times speed
// - ident shows only right after monitor command
// - scale pre/working write and read commands
// - ramp-down 24 bits, upper read by mode
// - mode 0: signed offset to computed point
// - mode 1: decelerate when remaining below value
// - accel range clamps to 50000, scaled
// - accel range zero uses half speed span
// - accel s-curve pre/working command codes
// - decel range clamps to 50000, scaled
// - decel range zero uses half speed span
// - decel s-curve pre/working command codes
// - 17-bit correction speed, no pre-register
// - correction speed clamps to 100000, scaled
// - correction speed drives backlash, origin reverse
module spdp_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // command port
    input wire logic [15:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [31:0] cmd_rdata,
    // speed generator side
    input wire logic [16:0] high_speed_reg,
    input wire logic [16:0] low_speed_reg,
    input wire logic [16:0] sel_speed,
    input wire logic use_correction,
    input wire logic op_start,
    // ramp-down inputs
    input wire logic rampdown_manual_sel,
    input wire logic [27:0] remaining_pulses,
    input wire logic [27:0] auto_decel_point,
    // results
    output logic [27:0] pulse_rate,
    output logic [26:0] accel_span,
    output logic [26:0] decel_span,
    output logic [27:0] correction_rate,
    output logic decel_start
);
    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [10:0] speed_scale_prebuf_r;
    logic [10:0] speed_scale_reg_r;
    logic [23:0] rampdown_point_prebuf_r;
    logic [23:0] rampdown_point_reg_r;
    logic [15:0] accel_curve_prebuf_r;
    logic [15:0] accel_curve_reg_r;
    logic [15:0] decel_curve_prebuf_r;
    logic [15:0] decel_curve_reg_r;
    logic [16:0] correction_speed_reg_r;
    logic ident_armed_r;
    logic decel_start_r;
    logic [31:0] rdata_r;
    logic [16:0] speed_base;
    logic [15:0] accel_eff;
    logic [15:0] decel_eff;
    logic [16:0] corr_eff;
    logic [15:0] half_span;
    logic signed [29:0] auto_thresh;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] curve_clamp(input logic [15:0] v, input logic [15:0] h);
        logic [15:0] r;
        r = v;
        if (v == 16'h0000) begin
            r = h;
        end else if (v > spdp_pkg::CURVE_MAX) begin
            r = spdp_pkg::CURVE_MAX;
        end
        return r;
    endfunction

    function automatic logic [31:0] rdp_format(input logic [23:0] v, input logic manual);
        logic [31:0] r;
        r = manual ? {8'h00, v} : {{8{v[23]}}, v};
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // speed scale: pre-register, working register, copy on operation start
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            speed_scale_prebuf_r <= spdp_pkg::SCALE_RST;
            speed_scale_reg_r <= spdp_pkg::SCALE_RST;
        end else begin
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_SCALE_PRE) begin
                speed_scale_prebuf_r <= cmd_wdata[10:0];
            end
            // a direct write wins over the copy in the same cycle
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_SCALE) begin
                speed_scale_reg_r <= cmd_wdata[10:0];
            end else if (op_start) begin
                speed_scale_reg_r <= speed_scale_prebuf_r;
            end
        end
    end

    // ramp-down point: upper written bits are dropped
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rampdown_point_prebuf_r <= spdp_pkg::RDP_RST;
            rampdown_point_reg_r <= spdp_pkg::RDP_RST;
        end else begin
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_RDP_PRE) begin
                rampdown_point_prebuf_r <= cmd_wdata[23:0];
            end
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_RDP) begin
                rampdown_point_reg_r <= cmd_wdata[23:0];
            end else if (op_start) begin
                rampdown_point_reg_r <= rampdown_point_prebuf_r;
            end
        end
    end

    // acceleration s-curve range; stored raw, clamped where it is used
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            accel_curve_prebuf_r <= spdp_pkg::CURVE_RST;
            accel_curve_reg_r <= spdp_pkg::CURVE_RST;
        end else begin
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_ACC_PRE) begin
                accel_curve_prebuf_r <= cmd_wdata[15:0];
            end
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_ACC) begin
                accel_curve_reg_r <= cmd_wdata[15:0];
            end else if (op_start) begin
                accel_curve_reg_r <= accel_curve_prebuf_r;
            end
        end
    end

    // deceleration s-curve range
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            decel_curve_prebuf_r <= spdp_pkg::CURVE_RST;
            decel_curve_reg_r <= spdp_pkg::CURVE_RST;
        end else begin
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_DEC_PRE) begin
                decel_curve_prebuf_r <= cmd_wdata[15:0];
            end
            if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_DEC) begin
                decel_curve_reg_r <= cmd_wdata[15:0];
            end else if (op_start) begin
                decel_curve_reg_r <= decel_curve_prebuf_r;
            end
        end
    end

    // correction speed has no pre-register, so it changes at once
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            correction_speed_reg_r <= spdp_pkg::CORR_RST;
        end else if (cmd_wr && cmd_addr == spdp_pkg::CMD_WR_CORR) begin
            correction_speed_reg_r <= cmd_wdata[16:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ident monitor arms only the very next strobe; anything else disarms
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ident_armed_r <= 1'b0;
        end else if (cmd_wr || cmd_rd) begin
            ident_armed_r <= cmd_wr && cmd_addr == spdp_pkg::CMD_IDENT_MON;
        end
    end

    // read data stand for one cycle only, zero otherwise and when unmapped
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !cmd_rd) begin
            rdata_r <= 32'h00000000;
        end else begin
            unique case (cmd_addr)
                spdp_pkg::CMD_RD_SCALE_PRE: rdata_r <= {21'h000000, speed_scale_prebuf_r};
                spdp_pkg::CMD_RD_SCALE: begin
                    // upper half is zero unless the monitor command came just before
                    rdata_r <= {ident_armed_r ? spdp_pkg::IDENT_CODE : 16'h0000,
                                5'h00, speed_scale_reg_r};
                end
                spdp_pkg::CMD_RD_RDP_PRE: begin
                    rdata_r <= rdp_format(rampdown_point_prebuf_r, rampdown_manual_sel);
                end
                spdp_pkg::CMD_RD_RDP: begin
                    rdata_r <= rdp_format(rampdown_point_reg_r, rampdown_manual_sel);
                end
                spdp_pkg::CMD_RD_ACC_PRE: rdata_r <= {16'h0000, accel_curve_prebuf_r};
                spdp_pkg::CMD_RD_ACC: rdata_r <= {16'h0000, accel_curve_reg_r};
                spdp_pkg::CMD_RD_DEC_PRE: rdata_r <= {16'h0000, decel_curve_prebuf_r};
                spdp_pkg::CMD_RD_DEC: rdata_r <= {16'h0000, decel_curve_reg_r};
                spdp_pkg::CMD_RD_CORR: rdata_r <= {15'h0000, correction_speed_reg_r};
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end

    assign cmd_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // effective values; the host is trusted to keep ranges below half span
    always_comb begin
        // a high speed below the low speed would wrap, so it gives zero instead
        if (high_speed_reg > low_speed_reg) begin
            half_span = 16'((high_speed_reg - low_speed_reg) >> 1);
        end else begin
            half_span = 16'h0000;
        end
        accel_eff = curve_clamp(accel_curve_reg_r, half_span);
        decel_eff = curve_clamp(decel_curve_reg_r, half_span);
        corr_eff = correction_speed_reg_r;
        if (correction_speed_reg_r > spdp_pkg::CORR_MAX) begin
            corr_eff = spdp_pkg::CORR_MAX;
        end
        // backlash and origin-return reverse legs run at correction speed
        speed_base = use_correction ? corr_eff : sel_speed;
    end

    // scaled outputs, one registered multiplier each
    spdp_scale #(.AW(11), .BW(17)) u_rate (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .scale(speed_scale_reg_r),
        .base(speed_base),
        .product(pulse_rate)
    );

    spdp_scale #(.AW(11), .BW(16)) u_acc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .scale(speed_scale_reg_r),
        .base(accel_eff),
        .product(accel_span)
    );

    spdp_scale #(.AW(11), .BW(16)) u_dec (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .scale(speed_scale_reg_r),
        .base(decel_eff),
        .product(decel_span)
    );

    spdp_scale #(.AW(11), .BW(17)) u_corr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .scale(speed_scale_reg_r),
        .base(corr_eff),
        .product(correction_rate)
    );

    ////////////////////////////////////////////////////////////////////////
    // deceleration start: signed offset on the computed point, or a plain count
    assign auto_thresh = $signed({2'b00, auto_decel_point})
                       + $signed({{6{rampdown_point_reg_r[23]}}, rampdown_point_reg_r});

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            decel_start_r <= 1'b0;
        end else if (rampdown_manual_sel) begin
            decel_start_r <= {4'h0, remaining_pulses} < {8'h00, rampdown_point_reg_r};
        end else begin
            // negative offsets may push the point below zero: no early start then
            decel_start_r <= $signed({2'b00, remaining_pulses}) <= auto_thresh;
        end
    end

    assign decel_start = decel_start_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // the monitor arms the next strobe whatever the idle gap, so track the last strobe
    logic chk_mon_last_r;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            chk_mon_last_r <= 1'b0;
        end else if (cmd_wr || cmd_rd) begin
            chk_mon_last_r <= cmd_wr && cmd_addr == spdp_pkg::CMD_IDENT_MON;
        end
    end

    sequence s_rd_scale;
        cmd_rd && cmd_addr == spdp_pkg::CMD_RD_SCALE;
    endsequence

    property p_scale_low_bits;
        s_rd_scale |=> cmd_rdata[15:11] == 5'h00 && cmd_rdata[10:0] == $past(speed_scale_reg_r);
    endproperty
    a_scale_low_bits: assert property (p_scale_low_bits)
        else $error("scale read shows wrong low half");

    property p_ident_seen;
        s_rd_scale ##0 chk_mon_last_r |=> cmd_rdata[31:16] == spdp_pkg::IDENT_CODE;
    endproperty
    a_ident_seen: assert property (p_ident_seen)
        else $error("ident missing after monitor command");

    property p_ident_hidden;
        s_rd_scale ##0 !chk_mon_last_r |=> cmd_rdata[31:16] == 16'h0000;
    endproperty
    a_ident_hidden: assert property (p_ident_hidden)
        else $error("ident shown without monitor command");

    property p_scale_write;
        cmd_wr && cmd_addr == spdp_pkg::CMD_WR_SCALE |=> speed_scale_reg_r == $past(cmd_wdata[10:0]);
    endproperty
    a_scale_write: assert property (p_scale_write)
        else $error("scale working register not written");

    property p_rdp_sign;
        cmd_rd && cmd_addr == spdp_pkg::CMD_RD_RDP && !rampdown_manual_sel
            |=> cmd_rdata[31:24] == {8{cmd_rdata[23]}};
    endproperty
    a_rdp_sign: assert property (p_rdp_sign)
        else $error("ramp-down upper bits not sign copy");

    property p_manual_decel;
        rampdown_manual_sel && ({4'h0, remaining_pulses} < {8'h00, rampdown_point_reg_r})
            |=> decel_start;
    endproperty
    a_manual_decel: assert property (p_manual_decel)
        else $error("manual ramp-down point missed");

    property p_acc_clamp;
        accel_curve_reg_r > spdp_pkg::CURVE_MAX
            |=> accel_span == 27'($past(speed_scale_reg_r) * spdp_pkg::CURVE_MAX);
    endproperty
    a_acc_clamp: assert property (p_acc_clamp)
        else $error("accel range not clamped");

    property p_acc_zero;
        accel_curve_reg_r == 16'h0000 |=> accel_span == 27'($past(speed_scale_reg_r) * $past(half_span));
    endproperty
    a_acc_zero: assert property (p_acc_zero)
        else $error("accel zero not replaced by half span");

    property p_corr_clamp;
        correction_speed_reg_r > spdp_pkg::CORR_MAX
            |=> correction_rate == 28'($past(speed_scale_reg_r) * spdp_pkg::CORR_MAX);
    endproperty
    a_corr_clamp: assert property (p_corr_clamp)
        else $error("correction speed not clamped");

    property p_copy_on_start;
        op_start && !(cmd_wr && cmd_addr == spdp_pkg::CMD_WR_SCALE)
            |=> speed_scale_reg_r == $past(speed_scale_prebuf_r);
    endproperty
    a_copy_on_start: assert property (p_copy_on_start)
        else $error("pre-register not copied at start");
endmodule

// file: spdp_host.sv
`timescale 1ns/1ns
// host model that issues register commands over the plain command port
module spdp_host (
    // clock
    input wire logic clk_sys,
    // command port toward the device
    output logic [15:0] cmd_addr,
    output logic [31:0] cmd_wdata,
    output logic cmd_wr,
    output logic cmd_rd,
    input wire logic [31:0] cmd_rdata
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle values at time zero, strobes low
    initial begin
        cmd_addr = 16'h0000;
        cmd_wdata = 32'h00000000;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle write; released lines show the inverse so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk_sys);
        cmd_wr <= 1'b0;
        cmd_addr <= ~a;
        cmd_wdata <= ~d;
    endtask

    // one-cycle read; data is taken in the single cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk_sys);
        cmd_rd <= 1'b0;
        cmd_addr <= ~a;
        @(posedge clk_sys);
        d = cmd_rdata;
    endtask
endmodule

// file: speed_profile_param_regs_tb.sv
`timescale 1ns/1ns
// self-checking bench for the speed profile parameter registers
module speed_profile_param_regs_tb;
    // clock, reset and command port
    logic clk_sys;
    logic sys_rst;
    logic [15:0] cmd_addr;
    logic [31:0] cmd_wdata;
    logic cmd_wr;
    logic cmd_rd;
    logic [31:0] cmd_rdata;
    // speed generator side
    logic [16:0] high_speed_reg;
    logic [16:0] low_speed_reg;
    logic [16:0] sel_speed;
    logic use_correction;
    logic op_start;
    logic rampdown_manual_sel;
    logic [27:0] remaining_pulses;
    logic [27:0] auto_decel_point;
    logic [27:0] pulse_rate;
    logic [26:0] accel_span;
    logic [26:0] decel_span;
    logic [27:0] correction_rate;
    logic decel_start;
    int err_total;
    int comparisons;
    // pre-register table: pre write, pre read, working read, value, working before copy
    localparam logic [15:0] WPRE [4] = '{16'h00b5, 16'h00b6, 16'h00b9, 16'h00ba};
    localparam logic [15:0] RPRE [4] = '{16'h00c5, 16'h00c6, 16'h00c9, 16'h00ca};
    localparam logic [15:0] RWRK [4] = '{16'h00d5, 16'h00d6, 16'h00d9, 16'h00da};
    localparam logic [31:0] PVAL [4] = '{32'h5, 32'h64, 32'hffff, 32'h1234};
    localparam logic [31:0] WOLD [4] = '{32'h7ff, 32'h0, 32'h0, 32'h0};

    ////////////////////////////////////////////////////////////////////////////////
    // clock generator, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    spdp_host host (
        .clk_sys(clk_sys),
        .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata)
    );

    spdp_regs dut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata),
        .high_speed_reg(high_speed_reg),
        .low_speed_reg(low_speed_reg),
        .sel_speed(sel_speed),
        .use_correction(use_correction),
        .op_start(op_start),
        .rampdown_manual_sel(rampdown_manual_sel),
        .remaining_pulses(remaining_pulses),
        .auto_decel_point(auto_decel_point),
        .pulse_rate(pulse_rate),
        .accel_span(accel_span),
        .decel_span(decel_span),
        .correction_rate(correction_rate),
        .decel_start(decel_start)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run, shared by the main sequence and the watchdog
    task automatic stop_test;
        $display("counts: %0d mismatches in %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // compare of an output value; case inequality so an unknown never matches
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // compare of read-back data through the host model
    task automatic chk_rd(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.rd(a, d);
        chk_val(d, exp);
    endtask

    // results are registered, so let a few edges pass after an input change
    task automatic settle;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #2000000;
        err_total++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        err_total = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        high_speed_reg = 17'h003e8;
        low_speed_reg = 17'h000c8;
        sel_speed = 17'h003e8;
        use_correction = 1'b0;
        op_start = 1'b0;
        rampdown_manual_sel = 1'b0;
        remaining_pulses = 28'h0000fff;
        auto_decel_point = 28'h00001f4;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        // reset contents, unmapped code reads zero
        chk_rd(spdp_pkg::CMD_RD_SCALE, 32'h00000002);
        chk_rd(spdp_pkg::CMD_RD_ACC, 32'h00000000);
        chk_rd(spdp_pkg::CMD_RD_DEC, 32'h00000000);
        chk_rd(spdp_pkg::CMD_RD_CORR, 32'h00000000);
        chk_rd(16'h00ff, 32'h00000000);
        end_test("reset");
        // scale field width, ident bits not writable and shown only after monitor
        host.wr(spdp_pkg::CMD_WR_SCALE, 32'hffffffff);
        chk_rd(spdp_pkg::CMD_RD_SCALE, 32'h000007ff);
        host.wr(spdp_pkg::CMD_IDENT_MON, 32'h00000000);
        chk_rd(spdp_pkg::CMD_RD_SCALE, {spdp_pkg::IDENT_CODE, 16'h07ff});
        chk_rd(spdp_pkg::CMD_RD_SCALE, 32'h000007ff);
        end_test("scale_ident");
        // pre-registers buffer writes until the next operation starts
        for (int i = 0; i < 4; i++) begin
            host.wr(WPRE[i], PVAL[i]);
            chk_rd(RPRE[i], PVAL[i]);
            chk_rd(RWRK[i], WOLD[i]);
        end
        host.wr(spdp_pkg::CMD_IDENT_MON, 32'h00000000);
        chk_rd(spdp_pkg::CMD_RD_SCALE_PRE, 32'h00000005);
        @(posedge clk_sys);
        op_start <= 1'b1;
        @(posedge clk_sys);
        op_start <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            chk_rd(RWRK[i], PVAL[i]);
        end
        end_test("prebuffer");
        // s-curve clamp and scaling, scale is now 5
        settle();
        chk_val({5'h00, accel_span}, 32'h5 * 32'hc350);
        chk_val({5'h00, decel_span}, 32'h5 * 32'h1234);
        host.wr(spdp_pkg::CMD_WR_DEC, 32'h0000ffff);
        settle();
        chk_val({5'h00, decel_span}, 32'h5 * 32'hc350);
        // zero range uses half of high minus low; host keeps 1000/200 apart
        host.wr(spdp_pkg::CMD_WR_ACC, 32'h00000000);
        host.wr(spdp_pkg::CMD_WR_DEC, 32'h00000000);
        settle();
        chk_val({5'h00, accel_span}, 32'h5 * 32'h190);
        chk_val({5'h00, decel_span}, 32'h5 * 32'h190);
        end_test("scurve");
        // correction speed clamp, raw read-back, and rate source selection
        host.wr(spdp_pkg::CMD_WR_CORR, 32'hfffe1fff);
        chk_rd(spdp_pkg::CMD_RD_CORR, 32'h00001fff);
        host.wr(spdp_pkg::CMD_WR_CORR, 32'h0001ffff);
        settle();
        chk_val({4'h0, correction_rate}, 32'h5 * 32'h186a0);
        chk_val({4'h0, pulse_rate}, 32'h5 * 32'h3e8);
        @(posedge clk_sys);
        use_correction <= 1'b1;
        settle();
        chk_val({4'h0, pulse_rate}, 32'h5 * 32'h186a0);
        host.wr(spdp_pkg::CMD_WR_CORR, 32'h00001234);
        settle();
        chk_val({4'h0, pulse_rate}, 32'h5 * 32'h1234);
        end_test("correction");
        // manual ramp-down: strictly below the stored count of 100
        @(posedge clk_sys);
        rampdown_manual_sel <= 1'b1;
        remaining_pulses <= 28'h0000063;
        settle();
        chk_val({31'h0, decel_start}, 32'h1);
        @(posedge clk_sys);
        remaining_pulses <= 28'h0000064;
        settle();
        chk_val({31'h0, decel_start}, 32'h0);
        // offset -16 on a computed point of 500, upper written bits dropped
        host.wr(spdp_pkg::CMD_WR_RDP, 32'habfffff0);
        chk_rd(spdp_pkg::CMD_RD_RDP, 32'h00fffff0);
        @(posedge clk_sys);
        rampdown_manual_sel <= 1'b0;
        remaining_pulses <= 28'h00001e4;
        chk_rd(spdp_pkg::CMD_RD_RDP, 32'hfffffff0);
        chk_val({31'h0, decel_start}, 32'h1);
        @(posedge clk_sys);
        remaining_pulses <= 28'h00001e5;
        settle();
        chk_val({31'h0, decel_start}, 32'h0);
        end_test("rampdown");
        stop_test();
    end
endmodule
